// ### eeprom_write_all_cmd_pkg.sv
// Constants and types for the write-all serial memory block
// Notes on behaviour
// - Select falling right after a full write-all frame starts the self-timed fill.
// - The self-timed cycle finishes on its own count, needing no serial clock.
// - During the cycle the host selects the part and samples data out for status.
// - Write-all needs no prior erase; each word is simply overwritten.
// - Select dropping in any other clock slot starts nothing and changes nothing.
// - Frame is start bit 1, opcode 00, address prefix 01, then 8 or 16 data bits.
// - Status poll drives data out low while busy and high once ready.
// - Programming is refused after reset or disable until the enable command.
package eeprom_write_all_cmd_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int          ADDR_W16      = 6;
  localparam int          ADDR_W8       = 7;
  localparam logic [1:0]  OP_SPECIAL    = 2'h0;
  localparam logic [1:0]  PFX_WRITE_ALL = 2'h1;
  localparam logic [1:0]  PFX_ENABLE    = 2'h3;
  localparam logic [1:0]  PFX_DISABLE   = 2'h0;
  localparam int          CNT_W         = 5;
  // Bits in header: start + opcode + address
  localparam logic [4:0]  HDR_BITS16    = 5'h09;
  localparam logic [4:0]  HDR_BITS8     = 5'h0A;
  localparam logic [4:0]  DATA_BITS16   = 5'h10;
  localparam logic [4:0]  DATA_BITS8    = 5'h08;

  // ----------------------------------------------------------------------
  // Memory shape
  // ----------------------------------------------------------------------
  localparam int          WORDS16       = 64;
  localparam logic [6:0]  LAST_ADDR16   = 7'h3F;
  localparam logic [6:0]  LAST_ADDR8    = 7'h7F;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          PROG_TIME_US  = 5;
  localparam int          PROG_CYCLES   = (PROG_TIME_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] PROG_CNT      = 16'(PROG_CYCLES);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_ARMED = 2'b10,
    ST_BUSY = 2'b11
  } state_t;

  typedef struct packed {
    logic select;
    logic clk;
    logic data;
  } serial_in_t;

  typedef struct packed {
    logic data;
    logic oe;
  } serial_out_t;

endpackage : eeprom_write_all_cmd_pkg

// ### eeprom_write_all_cmd.sv
// Write-all frame decoder, self-timed fill and ready/busy status
module eeprom_write_all_cmd
  import eeprom_write_all_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire serial_in_t  pins_in,
  input  wire logic        org_x16,
  output serial_out_t      pins_out,
  output logic             busy,
  output logic             write_enabled,
  input  wire logic [6:0]  rd_addr,
  output logic [15:0]      rd_data
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Opcode and prefix nibble just below the start bit of nbits held bits
  function automatic logic [3:0] op_field(
    logic [24:0] sr,
    logic [4:0]  nbits
  );
    logic [4:0] top;
    top = 5'(nbits - 5'h02);
    return sr[top -: 4];
  endfunction : op_field

  // ----------------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------------
  logic [15:0]      mem [0:WORDS16-1];
  state_t           state_r;
  state_t           state_nxt;
  logic             sk_d_r;
  logic             cs_d_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [24:0]      shreg_r;
  logic             wen_r;
  logic [15:0]      timer_r;
  logic [6:0]       fill_addr_r;
  logic [15:0]      fill_data_r;
  logic             do_r;
  logic             oe_r;
  logic [15:0]      rd_data_r;

  // ----------------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------------
  // Delayed copies reset to the idle level, so no false edge after reset
  wire sk_rise = pins_in.clk & ~sk_d_r;
  wire cs_fall = ~pins_in.select & cs_d_r;
  wire cs_rise = pins_in.select & ~cs_d_r;

  // ----------------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------------
  wire [4:0] hdr_bits   = org_x16 ? HDR_BITS16 : HDR_BITS8;
  wire [4:0] data_bits  = org_x16 ? DATA_BITS16 : DATA_BITS8;
  wire [4:0] frame_bits = 5'(hdr_bits + data_bits);
  wire [4:0] last_bit   = 5'(frame_bits - 5'h01);
  wire [6:0] last_addr  = org_x16 ? LAST_ADDR16 : LAST_ADDR8;

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  // Header checked at the rise after its last bit
  wire [3:0]  hdr_ms  = op_field(shreg_r, hdr_bits);
  wire        hdr_ok  = (bit_cnt_r == hdr_bits);
  wire        is_en   = hdr_ok && (hdr_ms == {OP_SPECIAL, PFX_ENABLE});
  wire        is_dis  = hdr_ok && (hdr_ms == {OP_SPECIAL, PFX_DISABLE});
  wire [3:0]  fr_ms   = op_field(shreg_r, frame_bits);
  wire        is_write_all_cmd = (fr_ms == {OP_SPECIAL, PFX_WRITE_ALL});
  wire [15:0] fr_data = org_x16 ? shreg_r[15:0] : {8'h00, shreg_r[7:0]};

  // ----------------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------------
  wire shift_en   = (state_r == ST_SHIFT) && sk_rise;
  wire start_fill = (state_r == ST_ARMED) && (state_nxt == ST_BUSY);
  wire in_busy    = (state_r == ST_BUSY);
  wire word_due   = in_busy && (timer_r == 16'h0000);
  wire more_words = (fill_addr_r != last_addr);
  wire fill_done  = word_due && !more_words;

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (pins_in.select && sk_rise && pins_in.data) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!pins_in.select) begin
          state_nxt = ST_IDLE;
        end else if (sk_rise && bit_cnt_r == last_bit) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // Only this slot counts; a further clock edge voids the frame
        if (cs_fall && is_write_all_cmd && wen_r) begin
          state_nxt = ST_BUSY;
        end else if (cs_fall || sk_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // Frames are not decoded until the fill is over
        if (fill_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State and pin history
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      sk_d_r  <= 1'b0;
      cs_d_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sk_d_r  <= pins_in.clk;
      cs_d_r  <= pins_in.select;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction shifter
  // ----------------------------------------------------------------------
  // Start bit preloaded, so the register holds the whole frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r == ST_IDLE) begin
      bit_cnt_r <= 5'h01;
      shreg_r   <= 25'h0000001;
    end else if (shift_en) begin
      bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
      shreg_r   <= {shreg_r[23:0], pins_in.data};
    end
  end

  // ----------------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wen_r <= 1'b0;
    end else if (shift_en && is_en) begin
      wen_r <= 1'b1;
    end else if (shift_en && is_dis) begin
      wen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Self-timed fill
  // ----------------------------------------------------------------------
  // Each word gets its own programming time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_r <= 16'h0000;
    end else if (start_fill) begin
      timer_r <= PROG_CNT;
    end else if (in_busy && timer_r != 16'h0000) begin
      timer_r <= timer_r - 16'h0001;
    end else if (word_due && more_words) begin
      timer_r <= PROG_CNT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fill_addr_r <= 7'h00;
      fill_data_r <= 16'h0000;
    end else if (start_fill) begin
      fill_addr_r <= 7'h00;
      fill_data_r <= fr_data;
    end else if (word_due && more_words) begin
      fill_addr_r <= fill_addr_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------------
  // Direct overwrite of each word, no erase pass
  wire [5:0] fill_row = org_x16 ? fill_addr_r[5:0] : fill_addr_r[6:1];
  wire       fill_hi  = fill_addr_r[0];

  always_ff @(posedge ref_clk) begin
    if (word_due) begin
      if (org_x16) begin
        mem[fill_row] <= fill_data_r;
      end else if (fill_hi) begin
        mem[fill_row][15:8] <= fill_data_r[7:0];
      end else begin
        mem[fill_row][7:0] <= fill_data_r[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Backdoor read
  // ----------------------------------------------------------------------
  wire [5:0]  rd_row  = org_x16 ? rd_addr[5:0] : rd_addr[6:1];
  wire [15:0] rd_word = mem[rd_row];
  wire [7:0]  rd_byte = rd_addr[0] ? rd_word[15:8] : rd_word[7:0];
  wire [15:0] rd_sel  = org_x16 ? rd_word : {8'h00, rd_byte};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Ready/busy status
  // ----------------------------------------------------------------------
  // Driver released by deselect, or by a dummy one once ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oe_r <= 1'b0;
    end else if (!pins_in.select) begin
      oe_r <= 1'b0;
    end else if (cs_rise && state_r != ST_SHIFT) begin
      oe_r <= 1'b1;
    end else if (sk_rise && pins_in.data && !in_busy) begin
      oe_r <= 1'b0;
    end
  end

  // Follows the next state, so status lines up with busy
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      do_r <= 1'b1;
    end else begin
      do_r <= (state_nxt != ST_BUSY);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pins_out.data = do_r;
  assign pins_out.oe   = oe_r;
  assign busy          = in_busy;
  assign write_enabled = wen_r;
  assign rd_data       = rd_data_r;

endmodule : eeprom_write_all_cmd

// ### eeprom_write_all_cmd_assertions.sv
// Port checks for the write-all block
module eeprom_write_all_cmd_assertions
  import eeprom_write_all_cmd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire serial_in_t  pins_in,
  input wire serial_out_t pins_out,
  input wire logic        busy,
  input wire logic        write_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence run8; busy [*8]; endsequence
  rst_idle_a: assert property ($fell(sys_rst) |-> !busy && !write_enabled)
    else $error("not idle after reset");
  start_en_a: assert property ($rose(busy) |-> $past(write_enabled))
    else $error("fill without enable");
  start_desel_a: assert property ($rose(busy) |-> !pins_in.select)
    else $error("fill while selected");
  run_min_a: assert property ($rose(busy) |-> run8)
    else $error("fill ended early");
  busy_low_a: assert property (busy && $past(busy) && pins_out.oe |-> !pins_out.data)
    else $error("busy not shown low");
  ready_high_a: assert property (!busy && !$past(busy) && pins_out.oe |-> pins_out.data)
    else $error("ready not shown high");
  en_stable_a: assert property (busy && $past(busy) |-> $stable(write_enabled))
    else $error("enable changed while busy");
  desel_oe_a: assert property ($fell(pins_in.select) |-> ##[1:4] !pins_out.oe)
    else $error("output kept driving");
endmodule : eeprom_write_all_cmd_assertions
bind eeprom_write_all_cmd eeprom_write_all_cmd_assertions chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .pins_in(pins_in), .pins_out(pins_out),
  .busy(busy), .write_enabled(write_enabled));

// ### host_model.sv
// Host controller model driving the serial frame pins
module host_model
  import eeprom_write_all_cmd_pkg::*;
(
  input  wire logic ref_clk,
  output serial_in_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '0;
  task automatic frame(logic [24:0] b, int n, int x);
    pins.select <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < n + x; i++) begin
      pins.data <= (i < n) ? b[24-i] : 1'b1;
      pins.clk  <= 1'b0;
      repeat (2) @(posedge ref_clk);
      pins.clk  <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    pins.clk    <= 1'b0;
    pins.select <= 1'b0;
    pins.data   <= ~pins.data;
    repeat (4) @(posedge ref_clk);
  endtask : frame
  task automatic poll(logic s);
    pins.select <= s;
    repeat (3) @(posedge ref_clk);
  endtask : poll
endmodule : host_model

// ### eeprom_write_all_cmd_tb.sv
// Self-checking bench for the write-all block
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module eeprom_write_all_cmd_tb
  import eeprom_write_all_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        org_x16 = 1'b1;
  logic [6:0]  rd_addr = 7'h00;
  logic [15:0] rd_data;
  logic        busy;
  logic        write_enabled;
  serial_in_t  pins_in;
  serial_out_t pins_out;
  int          num_errors = 0;
  int          cmp_count = 0;
  eeprom_write_all_cmd dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .pins_in(pins_in),
    .org_x16(org_x16), .pins_out(pins_out), .busy(busy),
    .write_enabled(write_enabled), .rd_addr(rd_addr), .rd_data(rd_data));
  host_model host (.ref_clk(ref_clk), .pins(pins_in));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic fill_frame(logic [15:0] d, int n, int x, logic b);
    host.frame({9'h110, d}, n, x);
    `CHK(busy, b)
  endtask : fill_frame
  task automatic idle_wait;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge ref_clk);
    if (busy !== 1'b0) begin
      num_errors++;
      test_done();
    end
  endtask : idle_wait
  task automatic rd(logic [6:0] a, logic [15:0] e);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    `CHK(rd_data, e)
  endtask : rd
  task automatic t_locked;
    `CHK(write_enabled, 1'b0)
    fill_frame(16'hFFFF, 25, 0, 1'b0);
  endtask : t_locked
  task automatic t_fill;
    host.frame(25'h1300000, 9, 1);
    `CHK(write_enabled, 1'b1)
    fill_frame(16'hA5C3, 25, 0, 1'b1);
    host.poll(1'b1);
    `CHK(pins_out, 2'h1)
    idle_wait();
    repeat (2) @(posedge ref_clk);
    `CHK(pins_out, 2'h3)
    host.poll(1'b0);
    rd(7'h00, 16'hA5C3);
    rd(7'h3F, 16'hA5C3);
  endtask : t_fill
  task automatic t_slot;
    fill_frame(16'h1234, 25, 1, 1'b0);
    fill_frame(16'h1234, 24, 0, 1'b0);
    rd(7'h10, 16'hA5C3);
  endtask : t_slot
  task automatic t_busy_ign;
    fill_frame(16'h5A5A, 25, 0, 1'b1);
    fill_frame(16'hFFFF, 25, 0, 1'b1);
    idle_wait();
    rd(7'h20, 16'h5A5A);
  endtask : t_busy_ign
  task automatic t_x8;
    org_x16 <= 1'b0;
    host.frame({10'h220, 8'hC3, 7'h00}, 18, 0);
    `CHK(busy, 1'b1)
    idle_wait();
    rd(7'h05, 16'h00C3);
    org_x16 <= 1'b1;
  endtask : t_x8
  task automatic t_dis;
    host.frame(25'h1000000, 9, 1);
    `CHK(write_enabled, 1'b0)
    fill_frame(16'h0F0F, 25, 0, 1'b0);
    rd(7'h01, 16'hC3C3);
  endtask : t_dis
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_locked();
    t_fill();
    t_slot();
    t_busy_ign();
    t_x8();
    t_dis();
    test_done();
  end
endmodule : eeprom_write_all_cmd_tb
